/* File: common/cxd_pkg.sv */
// shared constants and types for the exception and debug entry block
package cxd_pkg;
  localparam int unsigned CLK_MHZ = 40;
  // byte addresses of the apb registers
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_STATUS = 8'h04;
  localparam logic [7:0] A_DEBUG  = 8'h08;
  localparam logic [7:0] A_CAUSE  = 8'h0c;
  localparam logic [7:0] A_EPC    = 8'h10;
  localparam logic [7:0] A_ERREPC = 8'h14;
  localparam logic [7:0] A_DEBUG_RESTART_PC   = 8'h18;
  localparam logic [7:0] A_BADVA  = 8'h1c;
  localparam logic [7:0] A_NEXTPC = 8'h20;
  // status fields
  localparam int unsigned ST_EXL = 1;
  localparam int unsigned ST_ERL = 2;
  localparam int unsigned ST_NMI = 19;
  localparam int unsigned ST_SR  = 20;
  localparam int unsigned ST_TS  = 21;
  localparam int unsigned ST_BEV = 22;
  localparam int unsigned ST_IM  = 8;
  localparam logic [31:0] STATUS_RST = 32'h0040_0004;
  // debug fields
  localparam int unsigned DB_DSS  = 0;
  localparam int unsigned DB_DIB  = 4;
  localparam int unsigned DB_DEBUG_INTERRUPT_FLAG = 5;
  localparam int unsigned DB_SST  = 8;
  localparam int unsigned DB_PTRP = 9;
  localparam int unsigned DB_PBRK = 12;
  localparam int unsigned DB_DM   = 30;
  localparam int unsigned DB_DBD  = 31;
  // cause fields
  localparam int unsigned CA_IP = 8;
  localparam int unsigned CA_WP = 22;
  localparam int unsigned CA_BD = 31;
  localparam int unsigned CA_EXC = 2;
  // exception codes
  localparam logic [4:0] EXC_INT = 5'h00;
  localparam logic [4:0] EXC_LOAD_ADDR_ERROR_CODE = 5'h04;
  localparam logic [4:0] EXC_STORE_ADDR_ERROR_CODE = 5'h05;
  localparam logic [4:0] EXC_WATCH = 5'h17;
  localparam logic [4:0] EXC_MACHINE_CHECK_CODE = 5'h18;
  // vectors
  localparam logic [31:0] VEC_RESET   = 32'hbfc0_0000;
  localparam logic [31:0] VEC_DBG     = 32'hbfc0_0480;
  localparam logic [31:0] VEC_DBG_PRB = 32'hff20_0200;
  localparam logic [31:0] VEC_GEN_BEV = 32'hbfc0_0200;
  localparam logic [31:0] VEC_GEN     = 32'h8000_0000;
  localparam logic [31:0] OFS_GEN     = 32'h0000_0180;
  localparam logic [31:0] PC_STEP     = 32'h0000_0004;

  typedef enum logic [3:0] {
    CXD_NONE  = 4'h0,
    CXD_SSTEP = 4'h1,
    CXD_DEBUG_INTERRUPT_FLAG  = 4'h3,
    CXD_NMI   = 4'h2,
    CXD_MCHK  = 4'h6,
    CXD_INT   = 4'h7,
    CXD_DIB   = 4'h5,
    CXD_WATCH = 4'h4,
    CXD_ADDR  = 4'hc
  } cxd_exc_t;

  function automatic logic [31:0] cxd_restart(input logic [31:0] pc,
                                              input logic        bd);
    cxd_restart = bd ? pc - PC_STEP : pc;
  endfunction
endpackage

/* File: src/cxd_sync.sv */
// two-flop synchroniser for pin level inputs
`timescale 1ns/1ps
module cxd_sync (
  input  wire logic i_mclk,
  input  wire logic i_rst_n,
  input  wire logic i_d,
  output logic      o_q
);
  logic meta_r;
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      meta_r <= 1'b0;
      o_q    <= 1'b0;
    end else begin
      meta_r <= i_d;
      o_q    <= meta_r;
    end
  end
endmodule

/* File: src/cxd_prio.sv */
// fixed priority chooser for pending exceptions
`timescale 1ns/1ps
module cxd_prio
  import cxd_pkg::*;
(
  input  wire logic     i_sstep,
  input  wire logic     i_debug_interrupt_flag,
  input  wire logic     i_nmi,
  input  wire logic     i_mchk,
  input  wire logic     i_int,
  input  wire logic     i_dib,
  input  wire logic     i_watch,
  input  wire logic     i_addr,
  output cxd_pkg::cxd_exc_t o_sel
);
  always_comb begin
    // single step outranks all but reset
    if (i_sstep)      o_sel = CXD_SSTEP;
    else if (i_debug_interrupt_flag)  o_sel = CXD_DEBUG_INTERRUPT_FLAG;
    else if (i_nmi)   o_sel = CXD_NMI;
    else if (i_mchk)  o_sel = CXD_MCHK;
    else if (i_addr)  o_sel = CXD_ADDR;
    else if (i_dib)   o_sel = CXD_DIB;
    else if (i_watch) o_sel = CXD_WATCH;
    else if (i_int)   o_sel = CXD_INT;
    else              o_sel = CXD_NONE;
  end
endmodule

/* File: src/cxd_top.sv */
// exception recognition and debug entry unit with apb register access
// Overview of operation
// - after debug return, one instruction or branch plus delay slot runs, then trap.
// - step trap enabled by single_step_enable, suppressed for the step after return.
// - step trap saves next pc, clears delay-slot flag, sets single_step_flag.
// - exceptions of stepped instruction taken; step trap then hits handler start.
// - other debug exceptions unchanged; break instruction restarts at itself.
// - step trap outranks everything except cold and soft reset.
// - debug interrupt from probe_break_request bit or external request pin.
// - nmi taken once per rising edge of its request.
// - nmi only at instruction boundary, no reset of other state.
// - nmi sets boot_vector_select, error_level, nmi flag; clears tlb_shutdown, soft flag.
// - nmi saves pc, or pc minus four in a delay slot, to error_restart_pc.
// - nmi jumps to the reset vector.
// - multiple tlb match blocks write, sets tlb_shutdown, machine check at 0x180.
// - tlb_shutdown is status only; software clears it.
// - interrupt when enabled and asserted; interrupt_pending shows requests.
// - hardware breakpoint match raises debug exception, sets instr_break_flag.
// - watch traps only when exception_level, error_level, debug_mode are zero.
// - watch_pending alone raises watch exception; handler must clear it.
// - fetch and data watch matches raise the same watch exception.
// - address error on misalignment or user kernel access, load or store code.
// - misaligned fetch puts bad address in restart pc and bad address reg.
// - debug vector chosen by probe trap bit.
`timescale 1ns/1ps
module cxd_top
  import cxd_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic [31:0]      o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  input  wire logic        i_nmi_req,
  input  wire logic        i_dbg_req,
  input  wire logic [7:0]  i_hw_int,
  input  wire logic        i_timer_int,
  input  wire logic        i_retire,
  input  wire logic [31:0] i_pc,
  input  wire logic        i_in_delay,
  input  wire logic        i_is_branch,
  input  wire logic        i_dret,
  input  wire logic        i_software_debug_break_instr,
  input  wire logic        i_user_mode,
  input  wire logic        i_fetch_mis,
  input  wire logic        i_ls_valid,
  input  wire logic        i_ls_store,
  input  wire logic [1:0]  i_ls_size,
  input  wire logic [31:0] i_ls_addr,
  input  wire logic        i_tlbw_multi,
  input  wire logic        i_ib_match,
  input  wire logic        i_watch_i,
  input  wire logic        i_watch_d,
  output logic             o_take,
  output logic [31:0]      o_vector,
  output logic [3:0]       o_exc,
  output logic             o_tlbw_block,
  output logic             o_debug_mode
);
  logic [31:0] status_r, debug_r, cause_r, epc_r, errepc_r, debug_restart_pc_r, badva_r;
  logic [31:0] nextpc_r;
  logic        nmi_s, dbg_s, nmi_d_r, nmi_pend_r;
  logic        ss_armed_r, ss_after_br_r, ss_trap_r;
  logic        ls_mis, ls_kern, addr_err, fetch_bad, watch_now, int_any;
  logic [10:0] ip_now;
  cxd_exc_t    sel;
  logic        wr, rd;

  cxd_sync u_sync_nmi (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     (i_nmi_req),
    .o_q     (nmi_s)
  );
  cxd_sync u_sync_dbg (
    .i_mclk  (i_mclk),
    .i_rst_n (i_rst_n),
    .i_d     (i_dbg_req),
    .o_q     (dbg_s)
  );

  assign wr = i_psel && i_penable && i_pwrite;
  assign rd = i_psel && !i_penable && !i_pwrite;

  // single step arming: skip the instruction(s) right after debug return
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      ss_armed_r    <= 1'b0;
      ss_after_br_r <= 1'b0;
    end else if (o_take) begin
      ss_armed_r    <= 1'b0;
      ss_after_br_r <= 1'b0;
    end else if (i_dret) begin
      ss_armed_r    <= debug_r[DB_SST];
      ss_after_br_r <= 1'b0;
    end else if (i_retire && ss_armed_r && i_is_branch) begin
      ss_after_br_r <= 1'b1;
    end
  end

  // trap fires once the stepped unit retired, branch waits for its slot
  always_comb begin
    ss_trap_r = ss_armed_r && debug_r[DB_SST] && !debug_r[DB_DM] &&
                i_retire && (ss_after_br_r || !i_is_branch);
  end

  assign ip_now = {i_timer_int, i_hw_int, cause_r[CA_IP+1:CA_IP]};
  assign int_any = |(ip_now & status_r[ST_IM+10:ST_IM]) && status_r[0] &&
                   !status_r[ST_EXL] && !status_r[ST_ERL] &&
                   !debug_r[DB_DM];
  assign ls_mis = i_ls_valid &&
                  ((i_ls_size == 2'd2 && i_ls_addr[1:0] != 2'b00) ||
                   (i_ls_size == 2'd1 && i_ls_addr[0]));
  assign ls_kern = i_ls_valid && i_user_mode && i_ls_addr[31];
  assign fetch_bad = i_fetch_mis || (i_user_mode && i_pc[31]);
  assign addr_err = fetch_bad || ls_mis || ls_kern;
  // watch immediate only with all three levels clear
  assign watch_now = !status_r[ST_EXL] && !status_r[ST_ERL] &&
                     !debug_r[DB_DM] &&
                     (i_watch_i || i_watch_d || cause_r[CA_WP]);

  cxd_prio u_prio (
    .i_sstep (ss_trap_r),
    .i_debug_interrupt_flag  ((dbg_s || debug_r[DB_PBRK]) && !debug_r[DB_DM]),
    .i_nmi   (nmi_pend_r && i_retire),
    .i_mchk  (i_tlbw_multi),
    .i_int   (int_any),
    .i_dib   (i_ib_match && i_retire && !debug_r[DB_DM]),
    .i_watch (watch_now),
    .i_addr  (addr_err),
    .o_sel   (sel)
  );

  // one nmi per rising edge, held until a boundary
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      nmi_d_r    <= 1'b0;
      nmi_pend_r <= 1'b0;
    end else begin
      nmi_d_r <= nmi_s;
      if (nmi_s && !nmi_d_r)
        nmi_pend_r <= 1'b1;
      else if (sel == CXD_NMI)
        nmi_pend_r <= 1'b0;
    end
  end

  // take strobe, vector and kind
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_take       <= 1'b0;
      o_vector     <= VEC_RESET;
      o_exc        <= 4'h0;
      o_tlbw_block <= 1'b0;
    end else begin
      o_take       <= (sel != CXD_NONE);
      o_exc        <= sel;
      o_tlbw_block <= i_tlbw_multi;
      unique case (sel)
        CXD_SSTEP, CXD_DEBUG_INTERRUPT_FLAG, CXD_DIB:
          o_vector <= debug_r[DB_PTRP] ? VEC_DBG_PRB : VEC_DBG;
        CXD_NMI:
          o_vector <= VEC_RESET;
        CXD_NONE:
          o_vector <= o_vector;
        default:
          o_vector <= (status_r[ST_BEV] ? VEC_GEN_BEV : VEC_GEN) + OFS_GEN;
      endcase
    end
  end

  // status register: nmi entry, tlb shutdown, software writes
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      status_r <= STATUS_RST;
    end else begin
      if (wr && i_paddr == A_STATUS)
        status_r <= i_pwdata;
      if (sel == CXD_NMI) begin
        status_r[ST_BEV] <= 1'b1;
        status_r[ST_TS]  <= 1'b0;
        status_r[ST_SR]  <= 1'b0;
        status_r[ST_NMI] <= 1'b1;
        status_r[ST_ERL] <= 1'b1;
      end else if (sel == CXD_MCHK) begin
        status_r[ST_TS]  <= 1'b1;
        status_r[ST_EXL] <= 1'b1;
      end else if (sel == CXD_INT || sel == CXD_WATCH || sel == CXD_ADDR) begin
        status_r[ST_EXL] <= 1'b1;
      end
    end
  end

  // debug register; hardware set wins over software write
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      debug_r <= 32'h0;
      debug_restart_pc_r  <= 32'h0;
    end else begin
      if (wr && i_paddr == A_DEBUG)
        debug_r <= i_pwdata;
      if (i_dret)
        debug_r[DB_DM] <= 1'b0;
      unique case (sel)
        CXD_SSTEP: begin
          debug_restart_pc_r <= nextpc_r;
          debug_r[DB_DBD] <= 1'b0;
          debug_r[DB_DSS] <= 1'b1;
          debug_r[DB_DM]  <= 1'b1;
        end
        CXD_DEBUG_INTERRUPT_FLAG: begin
          debug_restart_pc_r <= cxd_restart(i_pc, i_in_delay);
          debug_r[DB_DBD]  <= i_in_delay;
          debug_r[DB_DEBUG_INTERRUPT_FLAG] <= 1'b1;
          debug_r[DB_PBRK] <= 1'b0;
          debug_r[DB_DM]   <= 1'b1;
        end
        CXD_DIB: begin
          debug_restart_pc_r <= cxd_restart(i_pc, i_in_delay);
          debug_r[DB_DBD] <= i_in_delay;
          debug_r[DB_DIB] <= 1'b1;
          debug_r[DB_DM]  <= 1'b1;
        end
        default: begin
          if (i_software_debug_break_instr && i_retire && !debug_r[DB_DM]) begin
            debug_restart_pc_r <= cxd_restart(i_pc, i_in_delay);
            debug_r[DB_DBD] <= i_in_delay;
            debug_r[DB_DM]  <= 1'b1;
          end
        end
      endcase
    end
  end

  // next pc tracker: after a normal entry, step trap lands on the handler
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n)
      nextpc_r <= VEC_RESET;
    else if (sel != CXD_NONE && sel != CXD_SSTEP)
      nextpc_r <= (sel == CXD_NMI) ? VEC_RESET :
                  (status_r[ST_BEV] ? VEC_GEN_BEV : VEC_GEN) + OFS_GEN;
    else if (i_retire)
      nextpc_r <= i_pc + PC_STEP;
  end

  // cause, epc, error epc, bad address
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      cause_r  <= 32'h0;
      epc_r    <= 32'h0;
      errepc_r <= 32'h0;
      badva_r  <= 32'h0;
    end else begin
      if (wr && i_paddr == A_CAUSE) begin
        cause_r[CA_IP+1:CA_IP] <= i_pwdata[CA_IP+1:CA_IP];
        cause_r[CA_WP]         <= i_pwdata[CA_WP];
      end
      if (wr && i_paddr == A_EPC)
        epc_r <= i_pwdata;
      if (wr && i_paddr == A_ERREPC)
        errepc_r <= i_pwdata;
      cause_r[CA_IP+10:CA_IP+2] <= ip_now[10:2];
      // deferred watch sets the pending bit
      if ((i_watch_i || i_watch_d) &&
          (status_r[ST_EXL] || status_r[ST_ERL] || debug_r[DB_DM]))
        cause_r[CA_WP] <= 1'b1;
      if (sel == CXD_NMI)
        errepc_r <= cxd_restart(i_pc, i_in_delay);
      if (sel inside {CXD_MCHK, CXD_INT, CXD_WATCH, CXD_ADDR} &&
          !status_r[ST_EXL]) begin
        epc_r <= cxd_restart(i_pc, i_in_delay);
        cause_r[CA_BD] <= i_in_delay;
      end
      unique case (sel)
        CXD_MCHK:  cause_r[CA_EXC+4:CA_EXC] <= EXC_MACHINE_CHECK_CODE;
        CXD_INT:   cause_r[CA_EXC+4:CA_EXC] <= EXC_INT;
        CXD_WATCH: cause_r[CA_EXC+4:CA_EXC] <= EXC_WATCH;
        CXD_ADDR: begin
          cause_r[CA_EXC+4:CA_EXC] <=
            (!fetch_bad && i_ls_store) ? EXC_STORE_ADDR_ERROR_CODE : EXC_LOAD_ADDR_ERROR_CODE;
          badva_r <= fetch_bad ? i_pc : i_ls_addr;
        end
        default: ;
      endcase
    end
  end

  // apb read path, zero wait states
  always_ff @(posedge i_mclk) begin
    if (!i_rst_n) begin
      o_prdata  <= 32'h0;
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= i_psel && !i_penable;
      o_pslverr <= i_psel && !i_penable && (i_paddr > A_NEXTPC);
      if (rd) begin
        unique case (i_paddr)
          A_STATUS: o_prdata <= status_r;
          A_DEBUG:  o_prdata <= debug_r;
          A_CAUSE:  o_prdata <= cause_r;
          A_EPC:    o_prdata <= epc_r;
          A_ERREPC: o_prdata <= errepc_r;
          A_DEBUG_RESTART_PC:   o_prdata <= debug_restart_pc_r;
          A_BADVA:  o_prdata <= badva_r;
          A_NEXTPC: o_prdata <= nextpc_r;
          default:  o_prdata <= 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_n)
      o_debug_mode <= 1'b0;
    else
      o_debug_mode <= debug_r[DB_DM];
  end

  a_nmi_vector: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_NMI |=> o_take && o_vector == VEC_RESET)
    else $error("nmi vector wrong");
  a_nmi_status: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_NMI |=> status_r[ST_ERL] && status_r[ST_BEV] &&
    !status_r[ST_TS])
    else $error("nmi status wrong");
  a_sstep_first: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ss_trap_r |-> sel == CXD_SSTEP)
    else $error("single step lost priority");
  a_sstep_dbd: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_SSTEP |=> !debug_r[DB_DBD] && debug_r[DB_DSS])
    else $error("step flags wrong");
  a_mchk_ts: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_MCHK |=> status_r[ST_TS] && o_tlbw_block)
    else $error("machine check flags wrong");
  a_nmi_once: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_NMI |=> !nmi_pend_r || $rose(nmi_d_r))
    else $error("nmi taken twice");
  a_watch_defer: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    ((i_watch_i || i_watch_d) && status_r[ST_EXL]) |=>
    cause_r[CA_WP])
    else $error("watch not deferred");
  a_debug_interrupt_flag_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sel == CXD_DEBUG_INTERRUPT_FLAG |=> debug_r[DB_DEBUG_INTERRUPT_FLAG] && debug_r[DB_DM])
    else $error("debug interrupt flags wrong");
endmodule

/* File: test/cxd_sys_model.sv */
// system-side model driving the nmi, debug and interrupt request pins
`timescale 1ns/1ps
module cxd_sys_model (
  input  wire logic       i_mclk,
  input  wire logic       i_nmi_cmd,
  input  wire logic       i_dbg_cmd,
  input  wire logic [8:0] i_int_cmd,
  output logic            o_nmi_req,
  output logic            o_dbg_req,
  output logic [7:0]      o_hw_int,
  output logic            o_timer_int
);
  initial begin
    o_nmi_req = 1'b0;
    o_dbg_req = 1'b0;
    o_hw_int = 8'h00;
    o_timer_int = 1'b0;
  end
  // pins move just after an edge, as registered system logic would
  always @(posedge i_mclk) begin
    o_nmi_req <= i_nmi_cmd;
    o_dbg_req <= i_dbg_cmd;
    o_hw_int <= i_int_cmd[7:0];
    o_timer_int <= i_int_cmd[8];
  end
endmodule

/* File: test/cxd_top_test.sv */
// self-checking bench for the exception and debug entry unit
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_checks++; if ((gt) !== (ex)) begin \
  fails++; $display("MISMATCH %s exp %h got %h", nm, ex, gt); end end
module cxd_top_test;
  import cxd_pkg::*;
  localparam logic [31:0] GV  = VEC_GEN_BEV + OFS_GEN;
  localparam logic [31:0] BOOT_VECTOR_SELECT = 32'h1 << ST_BEV;
  logic i_mclk, i_rst_n, psel, penable, pwrite, rerr, seen_blk;
  logic [7:0] paddr;
  logic [31:0] pwdata, rdata, pc, ls_addr;
  logic nmi_cmd, dbg_cmd, retire, in_delay, dret, fetch_mis;
  logic ls_valid, ls_store, tlbw_multi, watch_d;
  logic [1:0] ls_size;
  logic [8:0] int_cmd;
  wire logic [31:0] o_prdata, o_vector;
  wire logic o_pready, o_pslverr, o_take, o_tlbw_block, o_debug_mode;
  wire logic [3:0] o_exc;
  wire logic nmi_req, dbg_req, timer_int;
  wire logic [7:0] hw_int;
  int fails = 0;
  int n_checks = 0;

  always #12.5 i_mclk = ~i_mclk;

  cxd_sys_model u_cxd_sys_model (.i_mclk(i_mclk), .i_nmi_cmd(nmi_cmd),
    .i_dbg_cmd(dbg_cmd), .i_int_cmd(int_cmd), .o_nmi_req(nmi_req),
    .o_dbg_req(dbg_req), .o_hw_int(hw_int), .o_timer_int(timer_int));

  cxd_top u_cxd_top (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr), .i_nmi_req(nmi_req), .i_dbg_req(dbg_req),
    .i_hw_int(hw_int), .i_timer_int(timer_int), .i_retire(retire),
    .i_pc(pc), .i_in_delay(in_delay), .i_is_branch(1'b0),
    .i_dret(dret), .i_software_debug_break_instr(1'b0), .i_user_mode(1'b0),
    .i_fetch_mis(fetch_mis), .i_ls_valid(ls_valid),
    .i_ls_store(ls_store), .i_ls_size(ls_size), .i_ls_addr(ls_addr),
    .i_tlbw_multi(tlbw_multi), .i_ib_match(1'b0), .i_watch_i(1'b0),
    .i_watch_d(watch_d), .o_take(o_take), .o_vector(o_vector),
    .o_exc(o_exc), .o_tlbw_block(o_tlbw_block),
    .o_debug_mode(o_debug_mode));

  task give_verdict;
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task stuck;
    fails++;
    give_verdict();
  endtask

  // request held until the edge where pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge i_mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge i_mclk);
      if (o_pready === 1'b1) break;
    end
    if (n == 16) stuck();
    q = o_prdata;
    e = o_pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0, rdata, rerr);
  endtask

  task automatic wait_take(input logic [3:0] e, input logic [31:0] v);
    int n;
    seen_blk = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge i_mclk);
      if (o_tlbw_block === 1'b1) seen_blk = 1'b1;
      if (o_take === 1'b1) break;
    end
    if (n == 40) stuck();
    `CHK("exc kind", e, o_exc)
    `CHK("vector", v, o_vector)
  endtask

  task automatic no_take(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      `CHK("no take", 1'b0, o_take)
    end
  endtask

  // one-cycle fetch or load/store request, then the expected entry
  task automatic addr_case(input logic f, input logic st,
                           input logic [1:0] sz, input logic [31:0] a,
                           input logic [4:0] code);
    wr(A_STATUS, BOOT_VECTOR_SELECT);
    @(posedge i_mclk);
    fetch_mis <= f;
    ls_valid <= !f;
    ls_store <= st;
    ls_size <= sz;
    ls_addr <= a;
    if (f) pc <= a;
    @(posedge i_mclk);
    fetch_mis <= 1'b0;
    ls_valid <= 1'b0;
    wait_take(CXD_ADDR, GV);
    pc <= 32'h8000_1000;
    rd(A_BADVA);
    `CHK("bad address", a, rdata)
    rd(A_CAUSE);
    `CHK("addr code", code, rdata[6:2])
    if (f) begin
      rd(A_EPC);
      `CHK("fetch restart", a, rdata)
    end
  endtask

  task automatic pulse_dret;
    @(posedge i_mclk);
    dret <= 1'b1;
    @(posedge i_mclk);
    dret <= 1'b0;
  endtask

  initial begin
    {i_mclk, i_rst_n, psel, penable, pwrite, nmi_cmd, dbg_cmd} = '0;
    {in_delay, dret, fetch_mis, ls_valid, ls_store} = '0;
    {tlbw_multi, watch_d, ls_size, int_cmd, paddr} = '0;
    {pwdata, ls_addr} = '0;
    retire = 1'b1;
    pc = 32'h8000_1000;
    repeat (6) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    `CHK("reset vector", VEC_RESET, o_vector)
    rd(A_STATUS);
    `CHK("status reset", STATUS_RST, rdata)
    rd(8'h24);
    `CHK("unmapped err", 1'b1, rerr)
    `CHK("unmapped data", 32'h0, rdata)
    // masked request stays pending only
    wr(A_STATUS, BOOT_VECTOR_SELECT | 32'h1);
    int_cmd <= 9'h002;
    no_take(20);
    rd(A_CAUSE);
    `CHK("pending ip", 1'b1, rdata[CA_IP+3])
    wr(A_STATUS, BOOT_VECTOR_SELECT | 32'h1 | (32'h1 << (ST_IM + 3)));
    wait_take(CXD_INT, GV);
    int_cmd <= 9'h000;
    rd(A_CAUSE);
    `CHK("int code", EXC_INT, rdata[6:2])
    // exception_level is now set, so the watch hit is deferred
    @(posedge i_mclk);
    watch_d <= 1'b1;
    @(posedge i_mclk);
    watch_d <= 1'b0;
    no_take(10);
    rd(A_CAUSE);
    `CHK("watch pend", 1'b1, rdata[CA_WP])
    wr(A_STATUS, BOOT_VECTOR_SELECT);
    wait_take(CXD_WATCH, GV);
    rd(A_CAUSE);
    `CHK("watch code", EXC_WATCH, rdata[6:2])
    wr(A_CAUSE, 32'h0);
    addr_case(1'b1, 1'b0, 2'd2, 32'h8000_1002, EXC_LOAD_ADDR_ERROR_CODE);
    addr_case(1'b0, 1'b1, 2'd2, 32'h8000_2002, EXC_STORE_ADDR_ERROR_CODE);
    addr_case(1'b0, 1'b0, 2'd1, 32'h8000_2001, EXC_LOAD_ADDR_ERROR_CODE);
    wr(A_STATUS, BOOT_VECTOR_SELECT);
    @(posedge i_mclk);
    tlbw_multi <= 1'b1;
    @(posedge i_mclk);
    tlbw_multi <= 1'b0;
    wait_take(CXD_MCHK, GV);
    `CHK("tlbw blocked", 1'b1, seen_blk)
    rd(A_STATUS);
    `CHK("tlb shutdown", 1'b1, rdata[ST_TS])
    rd(A_CAUSE);
    `CHK("machine_check_code code", EXC_MACHINE_CHECK_CODE, rdata[6:2])
    // nmi held high with tlb_shutdown still set; cleared by entry
    pc <= 32'h8000_1004;
    in_delay <= 1'b1;
    nmi_cmd <= 1'b1;
    wait_take(CXD_NMI, VEC_RESET);
    no_take(30);
    rd(A_STATUS);
    `CHK("nmi status", BOOT_VECTOR_SELECT | (32'h1 << ST_NMI) | (32'h1 << ST_ERL),
         rdata & (BOOT_VECTOR_SELECT | (32'h7 << ST_NMI) | (32'h1 << ST_ERL)))
    rd(A_ERREPC);
    `CHK("nmi restart", 32'h8000_1000, rdata)
    nmi_cmd <= 1'b0;
    in_delay <= 1'b0;
    wr(A_DEBUG, 32'h1 << DB_PBRK);
    wait_take(CXD_DEBUG_INTERRUPT_FLAG, VEC_DBG);
    @(posedge i_mclk);
    `CHK("debug mode", 1'b1, o_debug_mode)
    rd(A_DEBUG);
    `CHK("debug_interrupt_flag flag", 2'b01, {rdata[DB_DBD], rdata[DB_DEBUG_INTERRUPT_FLAG]})
    rd(A_DEBUG_RESTART_PC);
    `CHK("debug_interrupt_flag restart", 32'h8000_1004, rdata)
    // probe trap set: request from the pin inside a delay slot
    wr(A_DEBUG, 32'h1 << DB_PTRP);
    pulse_dret();
    in_delay <= 1'b1;
    dbg_cmd <= 1'b1;
    wait_take(CXD_DEBUG_INTERRUPT_FLAG, VEC_DBG_PRB);
    dbg_cmd <= 1'b0;
    rd(A_DEBUG_RESTART_PC);
    `CHK("debug_interrupt_flag slot pc", 32'h8000_1000, rdata)
    rd(A_DEBUG);
    `CHK("debug_interrupt_flag slot", 1'b1, rdata[DB_DBD])
    // one instruction after return, then the step trap
    wr(A_DEBUG, 32'h1 << DB_SST);
    in_delay <= 1'b0;
    pc <= 32'h8000_3000;
    pulse_dret();
    pc <= 32'h8000_3004;
    wait_take(CXD_SSTEP, VEC_DBG);
    rd(A_DEBUG);
    `CHK("step flag", 2'b01, {rdata[DB_DBD], rdata[DB_DSS]})
    rd(A_DEBUG_RESTART_PC);
    `CHK("step restart", 32'h8000_3004, rdata)
    give_verdict();
  end
endmodule
